// ==== shared/vmd_pkg.sv ====
// Operation
// - decode one contiguous block inside the 24-bit vme address space
// - on a hit pass the address, a23..a20 zeroed for a 20-bit board, and issue matching memory read or write
// - block size is any power of two from 256 bytes to 16 mbytes
// - block start is a whole multiple of the block size
// - each address bit a23..a8 is compared or ignored on its own
// - base setting is two bytes, section 1..8 map a23..a16 and a15..a8
// - a base section that is on matches an address bit of 0
// - mask setting is two bytes, section 1..8 map a23..a16 and a15..a8
// - mask on bits are compared, respond only when all of them match
// - mask off bits are ignored and passed through unchanged
// - a7..a0 never compared, always forwarded
// - attached board may be a 20-bit or 24-bit memory slave
// - all mask off with all base on never selects the window
package vmd_pkg;

    // ==========================================================
    // widths
    localparam int VMD_ADDR_W = 24;
    localparam int VMD_CMP_LO = 8;
    localparam int VMD_NARROW_W = 20;
    localparam int VMD_REG_AW = 8;
    localparam int VMD_CNT_W = 16;

    // ==========================================================
    // register offsets
    localparam logic [7:0] VMD_OFS_BASE = 8'h00;
    localparam logic [7:0] VMD_OFS_MASK = 8'h04;
    localparam logic [7:0] VMD_OFS_CTRL = 8'h08;
    localparam logic [7:0] VMD_OFS_STATUS = 8'h0C;
    localparam logic [7:0] VMD_OFS_LAST = 8'h10;
    localparam logic [7:0] VMD_OFS_HITS = 8'h14;
    localparam logic [7:0] VMD_OFS_MISSES = 8'h18;

    // ==========================================================
    // field positions
    localparam int VMD_CTRL_WIDE_BIT = 0;
    localparam int VMD_ST_OFF_BIT = 0;
    localparam int VMD_ST_CYC_BIT = 1;
    localparam int VMD_ST_HIT_BIT = 2;
    localparam int VMD_ST_RD_BIT = 3;
    localparam int VMD_ST_WR_BIT = 4;
    localparam int VMD_ST_WIDE_BIT = 5;

    // ==========================================================
    // reset values: window disabled, 24-bit board
    localparam logic [7:0] VMD_BASE_RST = 8'hFF;
    localparam logic [7:0] VMD_MASK_RST = 8'h00;
    localparam logic VMD_WIDE_RST = 1'b1;

    // one bit per switch section, bit 7 is section 1, 1 means on
    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } vmd_setting_type;

    typedef struct packed {
        logic [VMD_ADDR_W-1:0] addr;
        logic active;
        logic write;
    } vmd_cycle_type;

    typedef enum logic [1:0] {
        VMD_IDLE,
        VMD_READ,
        VMD_WRITE,
        VMD_PASS
    } vmd_state_type;

endpackage

// ==== hdl/vmd_window_match.sv ====
`timescale 1ns/1ps
module vmd_window_match
    import vmd_pkg::*;
(
    input wire logic [VMD_ADDR_W-1:VMD_CMP_LO] addr_i,
    input wire vmd_setting_type base_i,
    input wire vmd_setting_type mask_i,
    output logic hit_o,
    output logic off_o
);

    logic [VMD_ADDR_W-1:VMD_CMP_LO] base_bits;
    logic [VMD_ADDR_W-1:VMD_CMP_LO] mask_bits;
    logic [VMD_ADDR_W-1:VMD_CMP_LO] bit_ok;

    // ==========================================================
    // section 1 of each byte sits on the upper address bit
    assign base_bits = {base_i.high, base_i.low};
    assign mask_bits = {mask_i.high, mask_i.low};

    // ==========================================================
    // per bit compare
    for (genvar b = VMD_CMP_LO; b < VMD_ADDR_W; b++) begin : g_bit
        // on base section matches a zero address bit
        assign bit_ok[b] = !mask_bits[b] || (addr_i[b] == !base_bits[b]);
    end

    assign off_o = (mask_bits == '0) && (base_bits == '1);
    assign hit_o = (&bit_ok) && !off_o;

endmodule

// ==== hdl/vmd_memory_window.sv ====
`timescale 1ns/1ps
module vmd_memory_window
    import vmd_pkg::*;
#(
    parameter int ADDR_W = VMD_ADDR_W,
    parameter int CNT_W = VMD_CNT_W
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // vme side
    input wire logic [ADDR_W-1:0] vme_addr_i,
    input wire logic vme_cycle_i,
    input wire logic vme_write_i,
    // multibus side
    output logic [ADDR_W-1:0] mb_addr_o,
    output logic mb_mem_rd_o,
    output logic mb_mem_wr_o,
    // register port
    input wire logic [VMD_REG_AW-1:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o
);

    // ==========================================================
    // elaboration checks
    if (ADDR_W != VMD_ADDR_W) begin : g_bad_addr
        $error("vmd_memory_window serves a 24-bit address space only");
    end
    if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt
        $error("vmd_memory_window counter width must be 1 to 32");
    end

    // ==========================================================
    // declarations
    vmd_setting_type base_q;
    vmd_setting_type mask_q;
    logic wide_q;
    logic [ADDR_W-1:0] last_q;
    logic [CNT_W-1:0] hits_q;
    logic [CNT_W-1:0] misses_q;
    logic [CNT_W-1:0] hits_d;
    logic [CNT_W-1:0] misses_d;
    logic [ADDR_W-1:0] mb_addr_q;
    logic [ADDR_W-1:0] mb_addr_d;
    logic mb_rd_q;
    logic mb_wr_q;
    logic cyc_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    vmd_state_type state_q;
    vmd_state_type state_d;
    vmd_cycle_type cyc_in;
    logic hit;
    logic off;
    logic cyc_start;
    logic wr_base;
    logic wr_mask;
    logic wr_ctrl;
    logic clr_hits;
    logic clr_misses;

    // ==========================================================
    // inputs bundled for the decode
    assign cyc_in.addr = vme_addr_i;
    assign cyc_in.active = vme_cycle_i;
    assign cyc_in.write = vme_write_i;

    assign cyc_start = cyc_in.active && !cyc_q;

    // ==========================================================
    // window compare, low byte never looked at
    vmd_window_match u_match (
        .addr_i(cyc_in.addr[ADDR_W-1:VMD_CMP_LO]),
        .base_i(base_q),
        .mask_i(mask_q),
        .hit_o(hit),
        .off_o(off)
    );

    // ==========================================================
    // register write decode
    assign wr_base = reg_wr_i && (reg_addr_i == VMD_OFS_BASE);
    assign wr_mask = reg_wr_i && (reg_addr_i == VMD_OFS_MASK);
    assign wr_ctrl = reg_wr_i && (reg_addr_i == VMD_OFS_CTRL);
    assign clr_hits = reg_wr_i && (reg_addr_i == VMD_OFS_HITS);
    assign clr_misses = reg_wr_i && (reg_addr_i == VMD_OFS_MISSES);

    // ==========================================================
    // base setting
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            base_q.high <= VMD_BASE_RST;
            base_q.low <= VMD_BASE_RST;
        end else if (wr_base) begin
            base_q.high <= reg_wdata_i[15:8];
            base_q.low <= reg_wdata_i[7:0];
        end
    end

    // ==========================================================
    // compare mask setting
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            mask_q.high <= VMD_MASK_RST;
            mask_q.low <= VMD_MASK_RST;
        end else if (wr_mask) begin
            mask_q.high <= reg_wdata_i[15:8];
            mask_q.low <= reg_wdata_i[7:0];
        end
    end

    // ==========================================================
    // 20 or 24 bit attached board
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            wide_q <= VMD_WIDE_RST;
        end else if (wr_ctrl) begin
            wide_q <= reg_wdata_i[VMD_CTRL_WIDE_BIT];
        end
    end

    // ==========================================================
    // command state
    always_comb begin
        state_d = VMD_IDLE;
        if (cyc_in.active) begin
            if (hit && cyc_in.write) begin
                state_d = VMD_WRITE;
            end else if (hit) begin
                state_d = VMD_READ;
            end else begin
                state_d = VMD_PASS;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            state_q <= VMD_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            cyc_q <= 1'b0;
        end else begin
            cyc_q <= cyc_in.active;
        end
    end

    // ==========================================================
    // multibus command outputs, dropped once the cycle ends
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            mb_rd_q <= 1'b0;
            mb_wr_q <= 1'b0;
        end else begin
            case (state_d)
                VMD_READ: begin
                    mb_rd_q <= 1'b1;
                    mb_wr_q <= 1'b0;
                end
                VMD_WRITE: begin
                    mb_rd_q <= 1'b0;
                    mb_wr_q <= 1'b1;
                end
                default: begin
                    mb_rd_q <= 1'b0;
                    mb_wr_q <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // address pass-through, upper nibble parked for a 20-bit board
    always_comb begin
        mb_addr_d = cyc_in.addr;
        if (!wide_q) begin
            mb_addr_d[ADDR_W-1:VMD_NARROW_W] = '0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            mb_addr_q <= '0;
        end else begin
            mb_addr_q <= mb_addr_d;
        end
    end

    // ==========================================================
    // last address that hit the window
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            last_q <= '0;
        end else if (cyc_start && hit) begin
            last_q <= cyc_in.addr;
        end
    end

    // ==========================================================
    // per cycle counters, a count in the clear cycle is kept
    always_comb begin
        hits_d = hits_q;
        if (clr_hits) begin
            hits_d = '0;
        end
        if (cyc_start && hit) begin
            hits_d = (clr_hits ? CNT_W'(0) : hits_q) + CNT_W'(1);
        end
    end

    always_comb begin
        misses_d = misses_q;
        if (clr_misses) begin
            misses_d = '0;
        end
        if (cyc_start && !hit) begin
            misses_d = (clr_misses ? CNT_W'(0) : misses_q) + CNT_W'(1);
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            hits_q <= '0;
            misses_q <= '0;
        end else begin
            hits_q <= hits_d;
            misses_q <= misses_d;
        end
    end

    // ==========================================================
    // register read, data valid only in the cycle after the strobe
    always_comb begin
        rdata_d = '0;
        if (reg_rd_i) begin
            case (reg_addr_i)
                VMD_OFS_BASE: begin
                    rdata_d[15:0] = base_q;
                end
                VMD_OFS_MASK: begin
                    rdata_d[15:0] = mask_q;
                end
                VMD_OFS_CTRL: begin
                    rdata_d[VMD_CTRL_WIDE_BIT] = wide_q;
                end
                VMD_OFS_STATUS: begin
                    rdata_d[VMD_ST_OFF_BIT] = off;
                    rdata_d[VMD_ST_CYC_BIT] = cyc_q;
                    rdata_d[VMD_ST_HIT_BIT] = (state_q == VMD_READ) ||
                        (state_q == VMD_WRITE);
                    rdata_d[VMD_ST_RD_BIT] = mb_rd_q;
                    rdata_d[VMD_ST_WR_BIT] = mb_wr_q;
                    rdata_d[VMD_ST_WIDE_BIT] = wide_q;
                end
                VMD_OFS_LAST: begin
                    rdata_d[ADDR_W-1:0] = last_q;
                end
                VMD_OFS_HITS: begin
                    rdata_d[CNT_W-1:0] = hits_q;
                end
                VMD_OFS_MISSES: begin
                    rdata_d[CNT_W-1:0] = misses_q;
                end
                default: begin
                    rdata_d = '0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // ==========================================================
    // outputs
    assign mb_addr_o = mb_addr_q;
    assign mb_mem_rd_o = mb_rd_q;
    assign mb_mem_wr_o = mb_wr_q;
    assign reg_rdata_o = rdata_q;

endmodule

// ==== verif/vmd_memory_window_properties.sv ====
`timescale 1ns/1ps
module vmd_memory_window_properties
    import vmd_pkg::*;
#(
    parameter int ADDR_W = VMD_ADDR_W,
    parameter int CNT_W = VMD_CNT_W
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic [ADDR_W-1:0] vme_addr_i,
    input wire logic vme_cycle_i,
    input wire logic vme_write_i,
    input wire logic [ADDR_W-1:0] mb_addr_o,
    input wire logic mb_mem_rd_o,
    input wire logic mb_mem_wr_o,
    input wire logic [VMD_REG_AW-1:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o
);
    // ==========================================================
    // shadow of the window settings
    logic [15:0] base_q;
    logic [15:0] mask_q;
    logic wide_q;
    logic hit;
    logic off;
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            base_q <= 16'hFFFF;
            mask_q <= 16'h0000;
            wide_q <= 1'b1;
        end else if (reg_wr_i) begin
            if (reg_addr_i == VMD_OFS_BASE) base_q <= reg_wdata_i[15:0];
            if (reg_addr_i == VMD_OFS_MASK) mask_q <= reg_wdata_i[15:0];
            if (reg_addr_i == VMD_OFS_CTRL) wide_q <= reg_wdata_i[0];
        end
    end
    assign off = (mask_q == 16'h0000) && (base_q == 16'hFFFF);
    assign hit = ~|(mask_q & (vme_addr_i[ADDR_W-1:8] ~^ base_q)) && !off;

    // ==========================================================
    // properties
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    property p_fwd_low;
        $past(nrst_i) |-> mb_addr_o[19:0] == $past(vme_addr_i[19:0]);
    endproperty
    a_fwd_low: assert property (p_fwd_low) else $error("low address not forwarded");
    property p_fwd_high;
        $past(nrst_i) |-> mb_addr_o[23:20] == ($past(wide_q) ? $past(vme_addr_i[23:20]) : 4'h0);
    endproperty
    a_fwd_high: assert property (p_fwd_high) else $error("high nibble wrong");
    property p_rd_hit;
        vme_cycle_i && hit && !vme_write_i |=> mb_mem_rd_o && !mb_mem_wr_o;
    endproperty
    a_rd_hit: assert property (p_rd_hit) else $error("read hit without read");
    property p_wr_hit;
        vme_cycle_i && hit && vme_write_i |=> mb_mem_wr_o && !mb_mem_rd_o;
    endproperty
    a_wr_hit: assert property (p_wr_hit) else $error("write hit without write");
    property p_miss;
        !hit |=> !mb_mem_rd_o && !mb_mem_wr_o;
    endproperty
    a_miss: assert property (p_miss) else $error("command on a miss");
    property p_idle;
        !vme_cycle_i |=> !(mb_mem_rd_o || mb_mem_wr_o);
    endproperty
    a_idle: assert property (p_idle) else $error("command outside cycle");
    property p_off;
        off [*2] |-> !mb_mem_rd_o && !mb_mem_wr_o;
    endproperty
    a_off: assert property (p_off) else $error("disabled window selected");
    property p_rdata_idle;
        !reg_rd_i |=> reg_rdata_o == 32'h0000_0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
    c_rd: cover property (vme_cycle_i && hit && !vme_write_i);
    c_wr: cover property (vme_cycle_i && hit && vme_write_i);
    c_narrow: cover property (!wide_q && vme_cycle_i);
endmodule
bind vmd_memory_window vmd_memory_window_properties #(.ADDR_W(ADDR_W), .CNT_W(CNT_W))
    i_vmd_memory_window_properties (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .vme_addr_i(vme_addr_i), .vme_cycle_i(vme_cycle_i), .vme_write_i(vme_write_i),
    .mb_addr_o(mb_addr_o), .mb_mem_rd_o(mb_mem_rd_o), .mb_mem_wr_o(mb_mem_wr_o),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));

// ==== verif/vmd_board_model.sv ====
`timescale 1ns/1ps
module vmd_board_model
    import vmd_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic [VMD_ADDR_W-1:0] mb_addr_i,
    input wire logic mb_mem_rd_i,
    input wire logic mb_mem_wr_i,
    output logic [15:0] rd_count_o,
    output logic [15:0] wr_count_o,
    output logic [VMD_ADDR_W-1:0] last_addr_o
);
    logic rd_q = 1'b0;
    logic wr_q = 1'b0;
    initial begin
        rd_count_o = 16'h0000;
        wr_count_o = 16'h0000;
        last_addr_o = 24'h000000;
    end
    // a held command is one access, so only its start is counted
    always @(posedge core_clk_i) begin
        rd_q <= mb_mem_rd_i;
        wr_q <= mb_mem_wr_i;
        if (mb_mem_rd_i && !rd_q) rd_count_o <= rd_count_o + 16'h0001;
        if (mb_mem_wr_i && !wr_q) wr_count_o <= wr_count_o + 16'h0001;
        if (mb_mem_rd_i || mb_mem_wr_i) last_addr_o <= mb_addr_i;
    end
endmodule

// ==== verif/vmd_memory_window_test.sv ====
`timescale 1ns/1ps
module vmd_memory_window_test;
    import vmd_pkg::*;
    logic core_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [23:0] vme_addr_i = 24'h000000;
    logic vme_cycle_i = 1'b0;
    logic vme_write_i = 1'b0;
    logic [23:0] mb_addr_o;
    logic mb_mem_rd_o;
    logic mb_mem_wr_o;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [31:0] reg_rdata_o;
    logic [15:0] rd_n;
    logic [15:0] wr_n;
    logic [23:0] last_a;
    logic [31:0] rdv;
    int failures = 0;
    int cmp_count = 0;
    int cycles = 0;
    int exp_rd = 0;
    int exp_wr = 0;
    typedef struct packed {
        logic [15:0] base;
        logic [15:0] mask;
        logic [23:0] addr;
        logic wr;
        logic hit;
    } vmd_row_type;
    vmd_row_type rows [10] = '{
        '{16'hD7C0, 16'hFFC0, 24'h283F12, 1'b0, 1'b1},
        '{16'hD7C0, 16'hFFC0, 24'h284000, 1'b1, 1'b0},
        '{16'hD7C0, 16'hFFC0, 24'h27FFFF, 1'b0, 1'b0},
        '{16'hD7C0, 16'hFFC0, 24'h280000, 1'b1, 1'b1},
        '{16'hEDCB, 16'hFFFF, 24'h1234AB, 1'b0, 1'b1},
        '{16'hEDCB, 16'hFFFF, 24'h1235AB, 1'b1, 1'b0},
        '{16'h0000, 16'h0000, 24'hABCDEF, 1'b1, 1'b1},
        '{16'hFFFF, 16'h0000, 24'h000000, 1'b0, 1'b0},
        '{16'h0000, 16'h8000, 24'h800000, 1'b1, 1'b1},
        '{16'h0000, 16'h8000, 24'h7FFFFF, 1'b0, 1'b0}};
    vmd_memory_window i_vmd_memory_window (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
        .vme_addr_i(vme_addr_i), .vme_cycle_i(vme_cycle_i), .vme_write_i(vme_write_i),
        .mb_addr_o(mb_addr_o), .mb_mem_rd_o(mb_mem_rd_o), .mb_mem_wr_o(mb_mem_wr_o),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));
    vmd_board_model i_vmd_board_model (.core_clk_i(core_clk_i), .mb_addr_i(mb_addr_o),
        .mb_mem_rd_i(mb_mem_rd_o), .mb_mem_wr_i(mb_mem_wr_o), .rd_count_o(rd_n),
        .wr_count_o(wr_n), .last_addr_o(last_a));
    initial begin
        forever #5 core_clk_i = ~core_clk_i;
    end
    // ==========================================================
    // compare, bus and closing tasks
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask
    task automatic vme(input logic [23:0] a, input logic w, input logic h, input logic [23:0] ea);
        @(posedge core_clk_i);
        vme_addr_i <= a;
        vme_write_i <= w;
        vme_cycle_i <= 1'b1;
        @(posedge core_clk_i);
        #1 chk_bit(mb_mem_rd_o, h && !w);
        chk_bit(mb_mem_wr_o, h && w);
        chk_word({8'h00, mb_addr_o}, {8'h00, ea});
        @(posedge core_clk_i);
        vme_cycle_i <= 1'b0;
        @(posedge core_clk_i);
        #1 chk_bit(mb_mem_rd_o || mb_mem_wr_o, 1'b0);
        exp_rd += int'(h && !w);
        exp_wr += int'(h && w);
    endtask
    task automatic close_out();
        $display("failures=%0d cmp_count=%0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            close_out();
        end
    end
    // ==========================================================
    // main sequence
    initial begin
        repeat (5) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        #1 chk_word({6'h0, mb_addr_o, mb_mem_rd_o, mb_mem_wr_o}, 32'h0);
        reg_rd(VMD_OFS_BASE, rdv);
        chk_word(rdv, 32'h0000_FFFF);
        reg_rd(VMD_OFS_MASK, rdv);
        chk_word(rdv, 32'h0);
        reg_rd(VMD_OFS_STATUS, rdv);
        chk_word(rdv, 32'h21);
        foreach (rows[i]) begin
            reg_wr(VMD_OFS_BASE, {16'h0, rows[i].base});
            reg_wr(VMD_OFS_MASK, {16'h0, rows[i].mask});
            vme(rows[i].addr, rows[i].wr, rows[i].hit, rows[i].addr);
        end
        reg_rd(VMD_OFS_MASK, rdv);
        chk_word(rdv, 32'h0000_8000);
        reg_wr(VMD_OFS_BASE, 32'h0);
        reg_wr(VMD_OFS_MASK, 32'h0);
        reg_wr(VMD_OFS_CTRL, 32'h0);
        vme(24'hABCDEF, 1'b0, 1'b1, 24'h0BCDEF);
        reg_wr(VMD_OFS_CTRL, 32'h1);
        reg_wr(VMD_OFS_BASE, 32'h0000_EDCB);
        reg_wr(VMD_OFS_MASK, 32'h0000_FFFF);
        @(posedge core_clk_i);
        vme_addr_i <= 24'h123400;
        vme_write_i <= 1'b0;
        vme_cycle_i <= 1'b1;
        repeat (3) begin
            @(posedge core_clk_i);
            #1 chk_bit(mb_mem_rd_o, 1'b1);
        end
        // status while the read command is held: cycle, hit, read, wide
        reg_rd(VMD_OFS_STATUS, rdv);
        chk_word(rdv, 32'h0000_002E);
        @(posedge core_clk_i);
        vme_addr_i <= 24'h123500;
        @(posedge core_clk_i);
        #1 chk_bit(mb_mem_rd_o, 1'b0);
        exp_rd++;
        @(posedge core_clk_i);
        vme_cycle_i <= 1'b0;
        reg_rd(8'h1C, rdv);
        chk_word(rdv, 32'h0);
        chk_word({16'h0, rd_n}, 32'(exp_rd));
        chk_word({16'h0, wr_n}, 32'(exp_wr));
        chk_word({8'h00, last_a}, 32'h0012_3400);
        // ==========================================================
        // counters, last hit address, clear, then a reset in mid-run
        reg_rd(VMD_OFS_HITS, rdv);
        chk_word(rdv, 32'h0000_0007);
        reg_rd(VMD_OFS_MISSES, rdv);
        chk_word(rdv, 32'h0000_0005);
        reg_rd(VMD_OFS_LAST, rdv);
        chk_word(rdv, 32'h0012_3400);
        reg_wr(VMD_OFS_HITS, 32'h0);
        reg_rd(VMD_OFS_HITS, rdv);
        chk_word(rdv, 32'h0);
        @(posedge core_clk_i);
        nrst_i <= 1'b0;
        @(posedge core_clk_i);
        nrst_i <= 1'b1;
        reg_rd(VMD_OFS_BASE, rdv);
        chk_word(rdv, 32'h0000_FFFF);
        reg_rd(VMD_OFS_LAST, rdv);
        chk_word(rdv, 32'h0);
        close_out();
    end
endmodule
